/* File: rtl/spi_port_cfg.svh */
// Constants for the serial port: widths, counts and reset values.
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

`define SPI_BYTE_W 8
`define SPI_MSB 7
`define SPI_ECNT_W 4
`define SPI_LAST_EDGE 4'hF
`define SPI_FIRST_EDGE 4'h0
`define SPI_RATE_W 3
`define SPI_RATE_MAX 3'h5
`define SPI_HALF_BASE 8'h02
`define SPI_DIV_W 8
`define SPI_BYTE_RST 8'h00
`define SPI_DIV_RST 8'h00
`define SPI_DIV_ONE 8'h01

`endif

/* File: rtl/spi_port_pkg.sv */
// Types shared by the serial port design files.
package spi_port_pkg;

  // Control register fields
  typedef struct packed {
    logic port_interrupt_enable;
    logic port_enable_bit;
    logic master_select_bit;
  } ctrl_t;

  // Configuration fields of the control/status register
  typedef struct packed {
    logic clock_polarity;
    logic clock_phase;
    logic [2:0] clock_rate_select;
    logic soft_select_manage;
    logic soft_select_level;
  } cfg_t;

  // Status flags of the control/status register
  typedef struct packed {
    logic transfer_complete_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } status_t;

  // Master shift engine states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } mst_state_t;

endpackage

/* File: rtl/spi_rate_div.sv */
// Half-period tick generator for the master serial clock.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_cfg.svh"

module spi_rate_div #(
  parameter int RATE_W = `SPI_RATE_W
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_run,
  input wire logic [RATE_W-1:0] i_rate,
  output logic o_tick
);

  logic [`SPI_DIV_W-1:0] cnt;
  logic [`SPI_DIV_W-1:0] half;

  // Half period in clocks: fastest rate gives a quarter of the clock
  function automatic logic [`SPI_DIV_W-1:0] half_count(
    input logic [RATE_W-1:0] rate
  );
    logic [RATE_W-1:0] r;
    r = (rate > `SPI_RATE_MAX) ? `SPI_RATE_MAX : rate;
    return `SPI_HALF_BASE << r;
  endfunction

  assign half = half_count(i_rate);

  // Counter restarts whenever the engine is idle, so edge one is aligned
  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt <= `SPI_DIV_RST;
      o_tick <= 1'b0;
    end
    else if (!i_run)
    begin
      cnt <= `SPI_DIV_RST;
      o_tick <= 1'b0;
    end
    else if (cnt == half - `SPI_DIV_ONE)
    begin
      cnt <= `SPI_DIV_RST;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + `SPI_DIV_ONE;
      o_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: rtl/spi_port.sv */
// Serial peripheral port: master or slave byte shifter with CPU flags.
`timescale 1ns/1ns
`default_nettype none
`include "spi_port_cfg.svh"

// Functional notes
// - Bytes go out and come in most significant bit first.
// - Only the master starts transfers; its single clock times both lines.
// - Both ends use the same polarity and phase, four timing choices.
// - Master offers six clock rates, quarter of the clock at fastest.
// - With soft select on, the select pin is ignored; level bit used.
// - Phase 1 samples on the second edge, phase 0 on the first.
// - Phase 0 slave write with select still low is a write collision.
// - Master drives the serial clock with configured rate, polarity, phase.
// - Master and enable bits stay set only while select is high.
// - Master data write loads shifter and starts shifting at once.
// - Byte done sets complete flag; interrupt when enabled and unmasked.
// - Master clears complete flag: status access then data read.
// - Data writes are ignored while complete flag set until status read.
// - Slave mode: master bit clear, enable set, clock comes in.
// - Slave write loads shifter; shifting follows the master clock.
// - Slave clears complete flag: status access then data read or write.
// - Select low as master: mode fault, drop enable and master.
// - Write during transfer is dropped; collision flag set, no interrupt.
// - Byte done with flag set: overrun, keep old byte, status read clears.
module spi_port (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_ctrl_wr,
  input wire spi_port_pkg::ctrl_t i_ctrl_wdata,
  input wire logic i_csr_rd,
  input wire logic i_csr_wr,
  input wire spi_port_pkg::cfg_t i_csr_wdata,
  input wire logic i_data_wr,
  input wire logic [`SPI_BYTE_W-1:0] i_data_wdata,
  input wire logic i_data_rd,
  input wire logic i_cpu_irq_mask,
  output spi_port_pkg::ctrl_t o_ctrl,
  output spi_port_pkg::cfg_t o_cfg,
  output spi_port_pkg::status_t o_status,
  output logic [`SPI_BYTE_W-1:0] o_rx_data,
  output logic o_irq,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  input wire logic i_mosi,
  output logic o_mosi,
  output logic o_mosi_oe,
  input wire logic i_miso,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_ss_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic sck_s1, sck_s2, sck_d;
  logic mosi_s1, mosi_s2, miso_s1, miso_s2, ss_s1, ss_s2;
  spi_port_pkg::mst_state_t state;
  logic [`SPI_ECNT_W-1:0] ecnt;
  logic [`SPI_BYTE_W-1:0] tx_sh;
  logic [`SPI_BYTE_W-1:0] rx_sh;
  logic tc_armed, csr_rd_seen, csr_rd_prev, mode_fault_flag_armed;
  logic tick, mst, slv, ss_int, slv_sel, in_bit, busy;
  logic edge_ev, sample_ev, shift_ev, done, mode_fault_flag_ev;
  logic wr_block, wr_coll, wr_ok, start, clr_tc;
  logic [`SPI_BYTE_W-1:0] next_rx;

  // Shift a bit in at the low end
  function automatic logic [`SPI_BYTE_W-1:0] shl_in(
    input logic [`SPI_BYTE_W-1:0] v,
    input logic b
  );
    return {v[`SPI_MSB-1:0], b};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      {sck_s1, sck_s2, sck_d} <= 3'h0;
      {mosi_s1, mosi_s2, miso_s1, miso_s2} <= 4'h0;
      {ss_s1, ss_s2} <= 2'h3;
    end
    else
    begin
      sck_s1 <= i_sck;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      mosi_s1 <= i_mosi;
      mosi_s2 <= mosi_s1;
      miso_s1 <= i_miso;
      miso_s2 <= miso_s1;
      ss_s1 <= i_ss_n;
      ss_s2 <= ss_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode, select and edge decode

  assign mst = o_ctrl.port_enable_bit & o_ctrl.master_select_bit;
  assign slv = o_ctrl.port_enable_bit & ~o_ctrl.master_select_bit;
  assign ss_int = o_cfg.soft_select_manage ? o_cfg.soft_select_level
                                           : ss_s2;
  assign slv_sel = slv & ~ss_int;
  assign mode_fault_flag_ev = mst & ~ss_int;
  assign in_bit = mst ? miso_s2 : mosi_s2;
  // Master edges come from the divider, slave edges from the pin
  assign edge_ev = mst ? (state == spi_port_pkg::ST_SHIFT) & tick
                       : slv_sel & (sck_s2 != sck_d);
  // Sample edge is the first of each bit for phase 0, second for phase 1
  assign sample_ev = edge_ev & (ecnt[0] == o_cfg.clock_phase);
  // Phase 1 puts the first bit out on edge one, so no shift there
  assign shift_ev = edge_ev & ~sample_ev
                    & ~(o_cfg.clock_phase & (ecnt == `SPI_FIRST_EDGE));
  assign done = edge_ev & (ecnt == `SPI_LAST_EDGE);
  assign next_rx = sample_ev ? shl_in(rx_sh, in_bit) : rx_sh;
  // Phase 0 slave stays busy while selected, so a write needs a gap
  assign busy = mst ? (state == spi_port_pkg::ST_SHIFT)
                    : slv_sel & (~o_cfg.clock_phase
                                 | (ecnt != `SPI_FIRST_EDGE));

  ////////////////////////////////////////////////////////////////////////////
  // Data register write qualification

  assign wr_block = i_data_wr & o_status.transfer_complete_flag
                    & ~csr_rd_seen;
  assign wr_coll = i_data_wr & ~wr_block & busy;
  assign wr_ok = i_data_wr & ~wr_block & ~busy;
  assign start = wr_ok & mst & ~mode_fault_flag_ev;
  // Master clears on read only; a slave also on write
  assign clr_tc = tc_armed & (i_data_rd
                  | (i_data_wr & ~o_ctrl.master_select_bit));

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider for master mode

  spi_rate_div #(
    .RATE_W(`SPI_RATE_W)
  ) u_div (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_run(state == spi_port_pkg::ST_SHIFT),
    .i_rate(o_cfg.clock_rate_select),
    .o_tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Master engine state

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= spi_port_pkg::ST_IDLE;
    else
    begin
      case (state)
        spi_port_pkg::ST_IDLE:
          if (start)
            state <= spi_port_pkg::ST_SHIFT;
        spi_port_pkg::ST_SHIFT:
          if (done || !mst || mode_fault_flag_ev)
            state <= spi_port_pkg::ST_IDLE;
        default:
          state <= spi_port_pkg::ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge counter and shift registers

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      ecnt <= `SPI_FIRST_EDGE;
    else if (start || done || (!mst && !slv_sel)
             || (mst && state != spi_port_pkg::ST_SHIFT))
      ecnt <= `SPI_FIRST_EDGE;
    else if (edge_ev)
      ecnt <= ecnt + 4'h1;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tx_sh <= `SPI_BYTE_RST;
      rx_sh <= `SPI_BYTE_RST;
    end
    else
    begin
      if (wr_ok)
        tx_sh <= i_data_wdata;
      else if (shift_ev)
        tx_sh <= shl_in(tx_sh, 1'b0);
      rx_sh <= next_rx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer, kept apart so a read never sees a half byte

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rx_data <= `SPI_BYTE_RST;
    else if (done && !o_status.transfer_complete_flag)
      o_rx_data <= next_rx;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status-register sequence trackers

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      tc_armed <= 1'b0;
      csr_rd_seen <= 1'b0;
      csr_rd_prev <= 1'b0;
      mode_fault_flag_armed <= 1'b0;
    end
    else
    begin
      if (!o_status.transfer_complete_flag || clr_tc)
      begin
        tc_armed <= 1'b0;
        csr_rd_seen <= 1'b0;
      end
      else
      begin
        if (i_csr_rd || i_csr_wr)
          tc_armed <= 1'b1;
        if (i_csr_rd)
          csr_rd_seen <= 1'b1;
      end
      if (i_csr_rd)
        csr_rd_prev <= 1'b1;
      else if (i_data_rd || i_data_wr)
        csr_rd_prev <= 1'b0;
      if (!o_status.mode_fault_flag || i_ctrl_wr)
        mode_fault_flag_armed <= 1'b0;
      else if (i_csr_rd)
        mode_fault_flag_armed <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags; a setting event beats a clear in the same cycle

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_status <= '0;
    else
    begin
      if (done)
        o_status.transfer_complete_flag <= 1'b1;
      else if (clr_tc)
        o_status.transfer_complete_flag <= 1'b0;
      if (done && o_status.transfer_complete_flag)
        o_status.overrun_flag <= 1'b1;
      else if (i_csr_rd)
        o_status.overrun_flag <= 1'b0;
      if (wr_coll)
        o_status.write_collision_flag <= 1'b1;
      else if (csr_rd_prev && i_data_rd)
        o_status.write_collision_flag <= 1'b0;
      if (mode_fault_flag_ev)
        o_status.mode_fault_flag <= 1'b1;
      else if (mode_fault_flag_armed && i_ctrl_wr)
        o_status.mode_fault_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and configuration registers

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_ctrl <= '0;
    else if (mode_fault_flag_ev)
    begin
      o_ctrl.port_enable_bit <= 1'b0;
      o_ctrl.master_select_bit <= 1'b0;
    end
    else if (i_ctrl_wr)
    begin
      o_ctrl <= i_ctrl_wdata;
      // Mode fault pins both bits low except inside its clear sequence
      if (o_status.mode_fault_flag && !mode_fault_flag_armed)
      begin
        o_ctrl.port_enable_bit <= 1'b0;
        o_ctrl.master_select_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_cfg <= '0;
    else if (i_csr_wr)
      o_cfg <= i_csr_wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request; write collision alone never raises it

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= o_ctrl.port_interrupt_enable & ~i_cpu_irq_mask
               & (o_status.transfer_complete_flag
                  | o_status.mode_fault_flag
                  | o_status.overrun_flag);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers; the clock rests at the polarity level between bytes

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
      o_mosi <= 1'b0;
      o_mosi_oe <= 1'b0;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end
    else
    begin
      if (state == spi_port_pkg::ST_SHIFT && tick && mst)
        o_sck <= ~o_sck;
      else if (state != spi_port_pkg::ST_SHIFT)
        o_sck <= o_cfg.clock_polarity;
      o_sck_oe <= mst;
      o_mosi <= tx_sh[`SPI_MSB];
      o_mosi_oe <= mst;
      o_miso <= tx_sh[`SPI_MSB];
      o_miso_oe <= slv_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_start;
    @(posedge i_ref_clk) disable iff (i_reset)
    start |=> state == spi_port_pkg::ST_SHIFT && tx_sh == $past(i_data_wdata);
  endproperty
  a_start: assert property (p_start) else $error("write did not start");

  property p_block;
    @(posedge i_ref_clk) disable iff (i_reset)
    wr_block |=> tx_sh == $past(tx_sh) && !o_status.write_collision_flag
                 == !$past(o_status.write_collision_flag);
  endproperty
  a_block: assert property (p_block) else $error("blocked write acted");

  // Shift edges excluded so the held shifter is a fair test of the drop
  property p_coll;
    @(posedge i_ref_clk) disable iff (i_reset)
    (i_data_wr && busy && !wr_block && !shift_ev)
      |=> o_status.write_collision_flag && tx_sh == $past(tx_sh);
  endproperty
  a_coll: assert property (p_coll) else $error("collision not flagged");

  property p_ovr;
    @(posedge i_ref_clk) disable iff (i_reset)
    (done && o_status.transfer_complete_flag)
      |=> o_status.overrun_flag && $stable(o_rx_data);
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun mishandled");

  property p_mode_fault_flag;
    @(posedge i_ref_clk) disable iff (i_reset)
    mode_fault_flag_ev |=> o_status.mode_fault_flag && !o_ctrl.port_enable_bit
                && !o_ctrl.master_select_bit ##1 !o_sck_oe;
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault missed");

  property p_irq;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_status.transfer_complete_flag && o_ctrl.port_interrupt_enable
     && !i_cpu_irq_mask) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("no interrupt request");

  // Soft select held high: the pin level can never fault the master
  property p_soft_sel;
    @(posedge i_ref_clk) disable iff (i_reset)
    (o_cfg.soft_select_manage && o_cfg.soft_select_level && mst)
      |=> !$rose(o_status.mode_fault_flag);
  endproperty
  a_soft_sel: assert property (p_soft_sel) else $error("select source");

  property p_idle_sck;
    @(posedge i_ref_clk) disable iff (i_reset)
    (state == spi_port_pkg::ST_IDLE) [*2] |-> o_sck == $past(o_cfg.clock_polarity);
  endproperty
  a_idle_sck: assert property (p_idle_sck) else $error("idle clock level");

  property p_rxbuf;
    @(posedge i_ref_clk) disable iff (i_reset)
    (done && !o_status.transfer_complete_flag)
      |=> o_rx_data == $past(next_rx) && o_status.transfer_complete_flag;
  endproperty
  a_rxbuf: assert property (p_rxbuf) else $error("buffer not loaded");

  property p_clr;
    @(posedge i_ref_clk) disable iff (i_reset)
    (tc_armed && i_data_rd && !done) |=> !o_status.transfer_complete_flag;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");

  c_master_byte: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    mst && done);
  c_slave_byte: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    slv && done);
  c_overrun: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    done && o_status.transfer_complete_flag);
  c_fault: cover property (@(posedge i_ref_clk) disable iff (i_reset)
    mode_fault_flag_ev);

endmodule
`default_nettype wire

/* File: verif/far_slave.sv */
// Behavioural serial slave that faces the port in master mode.
`timescale 1ns/1ns
`default_nettype none
module far_slave (
  input wire logic i_sck,
  input wire logic i_mosi,
  input wire logic i_sel_n,
  input wire logic i_clock_polarity,
  input wire logic i_clock_phase,
  input wire logic [7:0] i_tx,
  output logic [7:0] o_rx,
  output logic o_miso
);
  logic d = 1'b0;
  int k = 0;
  // Released line flips to the inverse so a stale bit cannot pass
  assign o_miso = i_sel_n ? ~d : d;
  // Select loads the byte; msb leads before any clock edge
  always @(negedge i_sel_n)
  begin
    k = 0;
    d = i_tx[7];
  end
  // Sample edge follows polarity and phase; the other edge shifts out
  always @(i_sck)
  begin
    if (!i_sel_n)
    begin
      if ((i_sck != i_clock_polarity) != i_clock_phase)
      begin
        o_rx = {o_rx[6:0], i_mosi};
        k++;
      end
      else
        d = (k < 8) ? i_tx[7-k] : ~d;
    end
  end
endmodule
`default_nettype wire

/* File: verif/spi_master_slave_port_bench.sv */
// Self-checking bench for the serial port in master and slave mode.
`timescale 1ns/1ns
`default_nettype none
module spi_master_slave_port_bench;
  logic ref_clk = 1'b0, reset = 1'b1, mask = 1'b0;
  logic ctrl_wr = 1'b0, csr_rd = 1'b0, csr_wr = 1'b0;
  logic data_wr = 1'b0, data_rd = 1'b0, ss_n = 1'b1, part_sel_n = 1'b1;
  logic tb_sck = 1'b0, tb_mosi = 1'b0, clock_polarity_v = 1'b0, clock_phase_v = 1'b0;
  logic [7:0] data_w = 8'h00, part_tx = 8'h00, part_rx, rx_q;
  spi_port_pkg::ctrl_t ctrl_w = 3'h0, ctrl_q;
  spi_port_pkg::cfg_t cfg_w = 7'h00, cfg_q;
  spi_port_pkg::status_t st;
  logic [3:0] st_v;
  logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, part_miso;
  logic sck_w, mosi_w, miso_w;
  int err_count = 0, checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////////////////
  // Pin levels: whoever has its enable up owns the wire
  assign sck_w = sck_oe ? sck_o : tb_sck;
  assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
  assign miso_w = miso_oe ? miso_o : part_miso;
  assign st_v = st;
  spi_port dut_u (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_ctrl_wr(ctrl_wr),
    .i_ctrl_wdata(ctrl_w), .i_csr_rd(csr_rd), .i_csr_wr(csr_wr),
    .i_csr_wdata(cfg_w), .i_data_wr(data_wr), .i_data_wdata(data_w),
    .i_data_rd(data_rd), .i_cpu_irq_mask(mask), .o_ctrl(ctrl_q),
    .o_cfg(cfg_q), .o_status(st), .o_rx_data(rx_q), .o_irq(irq),
    .i_sck(sck_w), .o_sck(sck_o), .o_sck_oe(sck_oe), .i_mosi(mosi_w),
    .o_mosi(mosi_o), .o_mosi_oe(mosi_oe), .i_miso(miso_w),
    .o_miso(miso_o), .o_miso_oe(miso_oe), .i_ss_n(ss_n)
  );
  far_slave far_u (
    .i_sck(sck_w), .i_mosi(mosi_w), .i_sel_n(part_sel_n),
    .i_clock_polarity(clock_polarity_v), .i_clock_phase(clock_phase_v), .i_tx(part_tx), .o_rx(part_rx),
    .o_miso(part_miso)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the expected run length
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One-cycle strobe: 0 ctrl wr, 1 csr rd, 2 csr wr, 3 data wr, 4 data rd
  task automatic cpu(input int op);
    @(negedge ref_clk);
    {data_rd, data_wr, csr_wr, csr_rd, ctrl_wr} = 5'h01 << op;
    @(negedge ref_clk);
    {data_rd, data_wr, csr_wr, csr_rd, ctrl_wr} = 5'h00;
  endtask
  // Bounded wait on one status bit (3 done, 2 coll, 1 overrun, 0 fault)
  task automatic wait_st(input int b);
    int n;
    n = 0;
    while (st_v[b] !== 1'b1 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("flag wait", 8'h01, {7'h00, st_v[b]});
  endtask
  // Config before control; soft select held high keeps master mode
  task automatic setup(input logic p, logic h, logic [2:0] r);
    clock_polarity_v = p;
    clock_phase_v = h;
    tb_sck = p;
    ctrl_w = 3'h0;
    cpu(0);
    cfg_w = {p, h, r, 2'h3};
    cpu(2);
    chk("cfg", {1'b0, cfg_w}, {1'b0, cfg_q});
    ctrl_w = 3'h7;
    cpu(0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_rates();
    int n;
    logic w;
    for (int k = 0; k < 6; k++)
    begin
      setup(k[0], k[1], k[2:0]);
      part_tx = 8'hA5 ^ k[7:0];
      part_sel_n = 1'b0;
      data_w = 8'h3C + k[7:0];
      cpu(3);
      for (int e = 0; e < 2; e++)
      begin
        n = 0;
        w = sck_w;
        while (sck_w === w && n < 300)
        begin
          @(negedge ref_clk);
          n++;
        end
      end
      chk("half period", 8'h02 << k, n[7:0]);
      wait_st(3);
      chk("far rx", data_w, part_rx);
      if (k > 0)
        chk("rx buffer", part_tx, rx_q);
      cpu(1);
      chk("idle clock", {7'h00, k[0]}, {7'h00, sck_w});
      chk("irq", 8'h01, {7'h00, irq});
      cpu(4);
      chk("done clear", 8'h00, {7'h00, st_v[3]});
      part_sel_n = 1'b1;
    end
    $display("test rates done");
  endtask
  task automatic t_flags();
    setup(1'b0, 1'b0, 3'h1);
    part_tx = 8'hE7;
    part_sel_n = 1'b0;
    data_w = 8'h81;
    cpu(3);
    tick(5);
    data_w = 8'h7E;
    cpu(3);
    wait_st(3);
    chk("collision", 8'h01, {7'h00, st_v[2]});
    chk("far rx", 8'h81, part_rx);
    mask = 1'b1;
    tick(3);
    chk("masked irq", 8'h00, {7'h00, irq});
    mask = 1'b0;
    data_w = 8'h55;
    cpu(3);
    tick(80);
    chk("inhibited", 8'h00, {7'h00, st_v[1]});
    cpu(1);
    part_sel_n = 1'b1;
    part_tx = 8'h99;
    tick(1);
    part_sel_n = 1'b0;
    data_w = 8'h42;
    cpu(3);
    wait_st(1);
    chk("kept byte", 8'hE7, rx_q);
    chk("far rx 2", 8'h42, part_rx);
    cpu(1);
    chk("overrun clr", 8'h00, {7'h00, st_v[1]});
    cpu(4);
    chk("flags clr", 8'h00, {4'h0, st_v});
    part_sel_n = 1'b1;
    $display("test flags done");
  endtask
  task automatic t_fault();
    setup(1'b0, 1'b0, 3'h1);
    ss_n = 1'b0;
    tick(8);
    chk("soft sel", 8'h07, {5'h00, ctrl_q});
    cfg_w = {2'h0, 3'h1, 2'h1};
    cpu(2);
    tick(8);
    chk("fault", 8'h01, {4'h0, st_v});
    chk("ctrl drop", 8'h04, {5'h00, ctrl_q});
    chk("fault irq", 8'h01, {7'h00, irq});
    ss_n = 1'b1;
    tick(4);
    cpu(1);
    ctrl_w = 3'h0;
    cpu(0);
    chk("fault clr", 8'h00, {4'h0, st_v});
    $display("test fault done");
  endtask
  task automatic t_slave();
    logic [7:0] got;
    cfg_w = 7'h00;
    cpu(2);
    ctrl_w = 3'h2;
    cpu(0);
    chk("slave sck oe", 8'h00, {7'h00, sck_oe});
    data_w = 8'hB4;
    cpu(3);
    data_w = 8'h11;
    ss_n = 1'b0;
    tick(6);
    for (int i = 7; i >= 0; i--)
    begin
      tb_mosi = data_w[i] ^ 1'b1;
      tick(8);
      got[i] = miso_w;
      tb_sck = 1'b1;
      tick(8);
      tb_sck = 1'b0;
      if (i == 4)
        cpu(3);
    end
    tick(8);
    ss_n = 1'b1;
    tick(6);
    chk("slave out", 8'hB4, got);
    chk("slave in", 8'hEE, rx_q);
    chk("slave flags", 8'h0C, {4'h0, st_v});
    cpu(1);
    cpu(3);
    chk("slave clr", 8'h00, {7'h00, st_v[3]});
    $display("test slave done");
  endtask
  // Phase 1 slave: select stays low over two bytes, flag cleared mid-byte
  task automatic t_slave_ph1();
    logic [7:0] got;
    logic [7:0] mb;
    cfg_w = 7'h20;
    cpu(2);
    ss_n = 1'b0;
    data_w = 8'h5A;
    cpu(3);
    for (int b = 0; b < 2; b++)
    begin
      mb = b ? 8'h69 : 8'hC3;
      for (int i = 7; i >= 0; i--)
      begin
        tb_mosi = mb[i];
        tb_sck = 1'b1;
        tick(8);
        got[i] = miso_w;
        tb_sck = 1'b0;
        tick(8);
        if (b == 1 && i == 4)
        begin
          chk("ph1 rx 1", 8'hC3, rx_q);
          cpu(1);
          cpu(4);
        end
      end
      if (b == 0)
        chk("ph1 out", 8'h5A, got);
    end
    ss_n = 1'b1;
    tick(6);
    chk("ph1 in", 8'h69, rx_q);
    chk("ph1 flags", 8'h08, {4'h0, st_v});
    $display("test slave phase 1 done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    tick(10);
    reset = 1'b0;
    chk("reset oe", 8'h00, {6'h00, sck_oe, mosi_oe});
    t_rates();
    t_flags();
    t_fault();
    t_slave();
    t_slave_ph1();
    tally_and_finish();
  end
endmodule
`default_nettype wire
